// [include/pcs_pkg.sv]
/*
  Package for the pump current source control block: register map,
  field layout, reset values, interrupt bits and timing counts.
  Assumes a 100 MHz system clock and a 32-bit AXI4-Lite register bus.
*/
package pcs_pkg;

  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [3:0] CFG_OFFSET = 4'h0;
  localparam logic [3:0] STATUS_OFFSET = 4'h4;
  localparam logic [3:0] IRQ_STATUS_OFFSET = 4'h8;
  localparam logic [3:0] IRQ_MASK_OFFSET = 4'hc;

  // ==========================================================
  // Configuration register fields
  localparam int GAIN_LSB = 0;
  localparam int GAIN_W = 3;
  localparam int CHANNEL_BIT = 3;
  localparam int TAG_BIT = 4;
  localparam int PULLDOWN_BIT = 5;
  localparam int ENABLE_BIT = 6;
  localparam int LIM_EN_BIT = 7;
  localparam int LIM_SYM_BIT = 8;
  localparam int LIM_REF_BIT = 9;
  localparam int CAP_LSB = 10;
  localparam int CAP_W = 6;
  localparam int CFG_W = 16;
  localparam logic [15:0] CFG_RESET = 16'h0020;

  // ==========================================================
  // Status register fields
  localparam int ST_ENABLED_BIT = 0;
  localparam int ST_LIMITER_BIT = 1;
  localparam int ST_BATTERY_BIT = 2;
  localparam int ST_GROUND_BIT = 3;
  localparam int ST_PULLDOWN_BIT = 4;
  localparam int ST_PARKING_BIT = 5;

  // ==========================================================
  // Interrupt status and mask fields
  localparam int IRQ_W = 4;
  localparam int IRQ_BATTERY_BIT = 0;
  localparam int IRQ_GROUND_BIT = 1;
  localparam int IRQ_LIMITER_BIT = 2;
  localparam int IRQ_REFUSED_BIT = 3;
  localparam logic [3:0] IRQ_MASK_RESET = 4'h0;

  // ==========================================================
  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int POR_FILTER_NS = 15000;
  localparam int POR_FILTER_CYCLES = (POR_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POR_CNT_W = 11;

  // ==========================================================
  // Bus channel states
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_RESP = 2'b10
  } pcs_bus_state_type;

endpackage

// [rtl/pcs_pump_source_ctrl.sv]
/*
  Pump current source control: configuration, enable gating, pull-down,
  limiter control and status, fault flags, AXI4-Lite slave, interrupt.
  Assumes comparator and bus inputs synchronous to clk.
*/
// Design decisions made here: the placing of the registers and register access over AXI4-Lite.
// Functional notes
// - Three-bit gain code picks one of eight output amplifier gains.
// - Channel bit picks output channel; unselected channel pins stay high impedance.
// - Tag switch of selected channel closes only when tag enable set.
// - After start-up source disabled, pins high impedance, parking active.
// - Pull-down on first output pin is connected by default.
// - Pull-down drops when source enabled or short to battery seen.
// - Pull-down bit honoured only while disabled and no fault present.
// - Enable with channel accepted only without short to battery; disables parking.
// - Limiter follows limiter-enable bit while source enabled.
// - Symmetry bit selects symmetric or asymmetric limiter window.
// - Limiter status reads one while limiter intervenes with source enabled.
// - Limiter reference input pin chosen by reference select bit.
// - Short to battery detection always active on all source pins.
// - Sense short to ground flagged while sense lies between thresholds.
// - Six-bit field selects connected compensation capacitors.
// - Supply fault held fifteen microseconds resets configuration and outputs.
`timescale 1ns/1ps
module pcs_pump_source_ctrl (
  input wire logic clk,
  input wire logic nrst,
  input wire logic porFault,
  input wire logic outBatteryCmp,
  input wire logic senseBatteryCmp,
  input wire logic senseGroundCmp,
  input wire logic limiterIntervene,
  output logic [2:0] outputGainSel,
  output logic ch1Drive,
  output logic ch2Drive,
  output logic tag1Close,
  output logic tag2Close,
  output logic parkingOn,
  output logic pulldownOn,
  output logic limiterOn,
  output logic limiterSymmetrySel,
  output logic limiterRefInputSel,
  output logic [5:0] compCapacitanceCfg,
  output logic limiterStatus,
  output logic batteryFault,
  output logic groundFault,
  output logic irq,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ==========================================================
  // Reset release and supply fault filter
  logic rstMeta;
  logic rstN;
  logic [pcs_pkg::POR_CNT_W-1:0] porCnt;
  logic porClear;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rstMeta <= 1'b0;
      rstN <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstN <= rstMeta;
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      porCnt <= '0;
      porClear <= 1'b0;
    end else if (!porFault) begin
      porCnt <= '0;
      porClear <= 1'b0;
    end else if (porCnt == pcs_pkg::POR_CNT_W'(pcs_pkg::POR_FILTER_CYCLES - 1)) begin
      porClear <= 1'b1;
    end else begin
      porCnt <= porCnt + 1'b1;
    end
  end

  // ==========================================================
  // Fault comparators
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      batteryFault <= 1'b0;
      groundFault <= 1'b0;
    end else begin
      batteryFault <= outBatteryCmp | senseBatteryCmp;
      groundFault <= senseGroundCmp;
    end
  end

  // ==========================================================
  // Register bus decode
  function automatic logic [1:0] reg_index(input logic [3:0] addr);
    reg_index = addr[3:2];
  endfunction

  function automatic logic [31:0] lane_mask(input logic [3:0] strb);
    lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction

  pcs_pkg::pcs_bus_state_type wrState;
  pcs_pkg::pcs_bus_state_type rdState;
  logic awHeld;
  logic wHeld;
  logic [3:0] awAddr;
  logic [31:0] wData;
  logic [3:0] wStrb;
  logic doWrite;
  logic doRead;
  logic [31:0] writeMask;
  logic [31:0] writeValue;
  logic [1:0] rdIndex;

  assign doWrite = (wrState == pcs_pkg::BUS_IDLE) && awHeld && wHeld;
  assign doRead = s_axi_arvalid && s_axi_arready;
  assign writeMask = lane_mask(wStrb);
  assign writeValue = wData & writeMask;
  assign rdIndex = reg_index(s_axi_araddr);

  // ==========================================================
  // Write channels: address and data taken in either order
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddr <= '0;
      wData <= '0;
      wStrb <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !awHeld && !(s_axi_awvalid && s_axi_awready) && (wrState == pcs_pkg::BUS_IDLE);
      s_axi_wready <= !wHeld && !(s_axi_wvalid && s_axi_wready) && (wrState == pcs_pkg::BUS_IDLE);
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (doWrite) begin
        awHeld <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (doWrite) begin
        wHeld <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      wrState <= pcs_pkg::BUS_IDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= pcs_pkg::RESP_OKAY;
    end else begin
      case (wrState)
        pcs_pkg::BUS_IDLE: begin
          if (doWrite) begin
            wrState <= pcs_pkg::BUS_RESP;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (awAddr == pcs_pkg::CFG_OFFSET || awAddr == pcs_pkg::IRQ_MASK_OFFSET) ?
              pcs_pkg::RESP_OKAY : pcs_pkg::RESP_SLVERR;
          end
        end
        pcs_pkg::BUS_RESP: begin
          if (s_axi_bready) begin
            wrState <= pcs_pkg::BUS_IDLE;
            s_axi_bvalid <= 1'b0;
          end
        end
        default: begin
          wrState <= pcs_pkg::BUS_IDLE;
          s_axi_bvalid <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // Configuration register
  logic [pcs_pkg::CFG_W-1:0] cfg;
  logic [pcs_pkg::CFG_W-1:0] next_cfg;
  logic cfgWrite;
  logic enableRequest;
  logic enableRefused;

  assign cfgWrite = doWrite && (awAddr == pcs_pkg::CFG_OFFSET);
  assign next_cfg = (cfg & ~writeMask[pcs_pkg::CFG_W-1:0]) | writeValue[pcs_pkg::CFG_W-1:0];
  assign enableRequest = next_cfg[pcs_pkg::ENABLE_BIT];
  assign enableRefused = cfgWrite && enableRequest && batteryFault;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      cfg <= pcs_pkg::CFG_RESET;
    end else if (porClear) begin
      cfg <= pcs_pkg::CFG_RESET;
    end else if (cfgWrite) begin
      cfg <= next_cfg;
      if (enableRefused) begin
        cfg[pcs_pkg::ENABLE_BIT] <= cfg[pcs_pkg::ENABLE_BIT];
        cfg[pcs_pkg::CHANNEL_BIT] <= cfg[pcs_pkg::CHANNEL_BIT];
      end
    end
  end

  // Gain, symmetry, reference and capacitors are the stored fields
  assign outputGainSel = cfg[pcs_pkg::GAIN_LSB +: pcs_pkg::GAIN_W];
  assign limiterSymmetrySel = cfg[pcs_pkg::LIM_SYM_BIT];
  assign limiterRefInputSel = cfg[pcs_pkg::LIM_REF_BIT];
  assign compCapacitanceCfg = cfg[pcs_pkg::CAP_LSB +: pcs_pkg::CAP_W];

  // ==========================================================
  // Source outputs, pull-down and limiter
  logic srcEn;
  assign srcEn = cfg[pcs_pkg::ENABLE_BIT];

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      ch1Drive <= 1'b0;
      ch2Drive <= 1'b0;
      tag1Close <= 1'b0;
      tag2Close <= 1'b0;
      parkingOn <= 1'b1;
    end else begin
      ch1Drive <= srcEn && !cfg[pcs_pkg::CHANNEL_BIT];
      ch2Drive <= srcEn && cfg[pcs_pkg::CHANNEL_BIT];
      tag1Close <= srcEn && !cfg[pcs_pkg::CHANNEL_BIT] && cfg[pcs_pkg::TAG_BIT];
      tag2Close <= srcEn && cfg[pcs_pkg::CHANNEL_BIT] && cfg[pcs_pkg::TAG_BIT];
      parkingOn <= !srcEn;
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      pulldownOn <= 1'b0;
    end else begin
      pulldownOn <= cfg[pcs_pkg::PULLDOWN_BIT] && !srcEn && !batteryFault && !groundFault;
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      limiterOn <= 1'b0;
      limiterStatus <= 1'b0;
    end else begin
      limiterOn <= srcEn && cfg[pcs_pkg::LIM_EN_BIT];
      limiterStatus <= srcEn && limiterOn && limiterIntervene;
    end
  end

  // ==========================================================
  // Interrupt status, clear on read; a new event wins over the clear
  logic [pcs_pkg::IRQ_W-1:0] irqStatus;
  logic [pcs_pkg::IRQ_W-1:0] irqMask;
  logic [pcs_pkg::IRQ_W-1:0] irqEvents;
  logic irqRead;

  assign irqEvents = {enableRefused, limiterStatus, groundFault, batteryFault};
  assign irqRead = doRead && (s_axi_araddr == pcs_pkg::IRQ_STATUS_OFFSET);

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      irqStatus <= '0;
    end else if (porClear) begin
      irqStatus <= '0;
    end else begin
      irqStatus <= (irqRead ? '0 : irqStatus) | irqEvents;
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      irqMask <= pcs_pkg::IRQ_MASK_RESET;
    end else if (porClear) begin
      irqMask <= pcs_pkg::IRQ_MASK_RESET;
    end else if (doWrite && (awAddr == pcs_pkg::IRQ_MASK_OFFSET)) begin
      irqMask <= (irqMask & ~writeMask[pcs_pkg::IRQ_W-1:0]) | writeValue[pcs_pkg::IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqStatus & irqMask);
    end
  end

  // ==========================================================
  // Read channel
  logic [31:0] statusWord;
  assign statusWord = {26'h0, parkingOn, pulldownOn, groundFault, batteryFault, limiterStatus, srcEn};

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      rdState <= pcs_pkg::BUS_IDLE;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= pcs_pkg::RESP_OKAY;
    end else begin
      case (rdState)
        pcs_pkg::BUS_IDLE: begin
          s_axi_arready <= !doRead;
          if (doRead) begin
            rdState <= pcs_pkg::BUS_RESP;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= s_axi_araddr[1:0] == 2'h0 ? pcs_pkg::RESP_OKAY : pcs_pkg::RESP_SLVERR;
            case (rdIndex)
              2'h0: s_axi_rdata <= {16'h0, cfg};
              2'h1: s_axi_rdata <= statusWord;
              2'h2: s_axi_rdata <= {28'h0, irqStatus};
              default: s_axi_rdata <= {28'h0, irqMask};
            endcase
          end
        end
        pcs_pkg::BUS_RESP: begin
          s_axi_arready <= 1'b0;
          if (s_axi_rready) begin
            rdState <= pcs_pkg::BUS_IDLE;
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
          end
        end
        default: begin
          rdState <= pcs_pkg::BUS_IDLE;
          s_axi_rvalid <= 1'b0;
          s_axi_arready <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // Checks
  sequence s_cfg_write_enable;
    cfgWrite && enableRequest;
  endsequence

  property p_refused_when_battery;
    @(posedge clk) disable iff (!rstN)
      (s_cfg_write_enable and batteryFault && !srcEn && !porClear) |=> !srcEn ##1 !ch1Drive && !ch2Drive;
  endproperty
  a_refused_when_battery: assert property (p_refused_when_battery) else $error("enable taken during battery short");

  property p_enable_taken;
    @(posedge clk) disable iff (!rstN)
      (s_cfg_write_enable and !batteryFault && !porClear) |=> srcEn ##1 !parkingOn;
  endproperty
  a_enable_taken: assert property (p_enable_taken) else $error("enable not taken or parking still on");

  property p_channel_select;
    @(posedge clk) disable iff (!rstN)
      srcEn |=> (ch2Drive == $past(cfg[pcs_pkg::CHANNEL_BIT])) && (ch1Drive != ch2Drive);
  endproperty
  a_channel_select: assert property (p_channel_select) else $error("wrong channel driven");

  property p_tag_switch;
    @(posedge clk) disable iff (!rstN)
      (tag1Close || tag2Close) |-> $past(cfg[pcs_pkg::TAG_BIT]) && (tag1Close ? ch1Drive : ch2Drive);
  endproperty
  a_tag_switch: assert property (p_tag_switch) else $error("tag switch closed without enable");

  property p_pulldown_off;
    @(posedge clk) disable iff (!rstN)
      (srcEn || batteryFault) |=> !pulldownOn;
  endproperty
  a_pulldown_off: assert property (p_pulldown_off) else $error("pull-down left on");

  property p_pulldown_follows_bit;
    @(posedge clk) disable iff (!rstN)
      (rstN && !srcEn && !batteryFault && !groundFault) |=> pulldownOn == $past(cfg[pcs_pkg::PULLDOWN_BIT]);
  endproperty
  a_pulldown_follows_bit: assert property (p_pulldown_follows_bit) else $error("pull-down ignores its bit");

  property p_limiter_disabled;
    @(posedge clk) disable iff (!rstN)
      !srcEn [*2] |=> !limiterOn && !limiterStatus;
  endproperty
  a_limiter_disabled: assert property (p_limiter_disabled) else $error("limiter active with source off");

  property p_limiter_follows;
    @(posedge clk) disable iff (!rstN)
      srcEn && cfg[pcs_pkg::LIM_EN_BIT] |=> limiterOn;
  endproperty
  a_limiter_follows: assert property (p_limiter_follows) else $error("limiter not switched on");

  property p_limiter_status;
    @(posedge clk) disable iff (!rstN)
      (srcEn && limiterOn && limiterIntervene) |=> limiterStatus;
  endproperty
  a_limiter_status: assert property (p_limiter_status) else $error("limiter status not reported");

  property p_fault_flags;
    @(posedge clk) disable iff (!rstN)
      rstN |=> batteryFault == $past(outBatteryCmp | senseBatteryCmp) && groundFault == $past(senseGroundCmp);
  endproperty
  a_fault_flags: assert property (p_fault_flags) else $error("fault flag does not follow detector");

  property p_por_clear;
    @(posedge clk) disable iff (!rstN)
      porClear |=> cfg == pcs_pkg::CFG_RESET ##1 !ch1Drive && !ch2Drive && parkingOn;
  endproperty
  a_por_clear: assert property (p_por_clear) else $error("supply fault did not restore defaults");

  property p_cfg_applied;
    @(posedge clk) disable iff (!rstN)
      (cfgWrite && !porClear) |=> outputGainSel == $past(next_cfg[pcs_pkg::GAIN_LSB +: pcs_pkg::GAIN_W]) &&
        compCapacitanceCfg == $past(next_cfg[pcs_pkg::CAP_LSB +: pcs_pkg::CAP_W]);
  endproperty
  a_cfg_applied: assert property (p_cfg_applied) else $error("settings not applied after write");

endmodule // pcs_pump_source_ctrl

// [tb/pcs_pump_cell_model.sv]
/*
  Pump cell model: comparator outputs and limiter action of the analog side.
  Assumes the bench sets shorts and overdrive just after clock edges.
*/
`timescale 1ns/1ps
module pcs_pump_cell_model (
  input wire logic clk,
  input wire logic ch1Drive,
  input wire logic ch2Drive,
  input wire logic limiterOn,
  input wire logic [1:0] batteryShort,
  input wire logic groundShort,
  input wire logic overdrive,
  output logic outBatteryCmp,
  output logic senseBatteryCmp,
  output logic senseGroundCmp,
  output logic limiterIntervene
);
  // ==========================================================
  // Comparators
  initial begin
    outBatteryCmp = 1'b0;
    senseBatteryCmp = 1'b0;
    senseGroundCmp = 1'b0;
    limiterIntervene = 1'b0;
  end
  always @(posedge clk) begin
    outBatteryCmp <= batteryShort[0];
    senseBatteryCmp <= batteryShort[1];
    senseGroundCmp <= groundShort;
  end
  // ==========================================================
  // Limiter acts only on a driven cell pushed out of range
  always @(posedge clk) begin
    limiterIntervene <= limiterOn && (ch1Drive || ch2Drive) && overdrive;
  end
endmodule // pcs_pump_cell_model

// [tb/pcs_pump_source_ctrl_tb.sv]
/*
  Testbench for the pump current source control: AXI4-Lite tasks, directed tests.
  Assumes the pump cell model drives the comparator inputs.
*/
`timescale 1ns/1ps
module pcs_pump_source_ctrl_tb;
  localparam logic [3:0] CFG = pcs_pkg::CFG_OFFSET;
  localparam logic [3:0] STA = pcs_pkg::STATUS_OFFSET;
  localparam logic [3:0] IST = pcs_pkg::IRQ_STATUS_OFFSET;
  localparam logic [3:0] MSK = pcs_pkg::IRQ_MASK_OFFSET;
  localparam logic [31:0] EN = 32'h1 << pcs_pkg::ENABLE_BIT;
  localparam logic [31:0] CH = 32'h1 << pcs_pkg::CHANNEL_BIT;
  localparam logic [31:0] TG = 32'h1 << pcs_pkg::TAG_BIT;
  localparam logic [31:0] PD = 32'h1 << pcs_pkg::PULLDOWN_BIT;
  localparam logic [31:0] LE = 32'h1 << pcs_pkg::LIM_EN_BIT;
  localparam logic [1:0] OK = pcs_pkg::RESP_OKAY;
  logic clk, nrst, porFault, groundShort, overdrive;
  logic [1:0] batteryShort;
  logic outBatteryCmp, senseBatteryCmp, senseGroundCmp, limiterIntervene;
  logic [2:0] outputGainSel;
  logic ch1Drive, ch2Drive, tag1Close, tag2Close, parkingOn, pulldownOn, limiterOn;
  logic limiterSymmetrySel, limiterRefInputSel, limiterStatus, batteryFault, groundFault, irq;
  logic [5:0] compCapacitanceCfg;
  logic [3:0] s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int errors, samples_checked;

  pcs_pump_source_ctrl dut_u (.clk(clk), .nrst(nrst), .porFault(porFault),
    .outBatteryCmp(outBatteryCmp), .senseBatteryCmp(senseBatteryCmp), .senseGroundCmp(senseGroundCmp),
    .limiterIntervene(limiterIntervene), .outputGainSel(outputGainSel), .ch1Drive(ch1Drive),
    .ch2Drive(ch2Drive), .tag1Close(tag1Close), .tag2Close(tag2Close), .parkingOn(parkingOn),
    .pulldownOn(pulldownOn), .limiterOn(limiterOn), .limiterSymmetrySel(limiterSymmetrySel),
    .limiterRefInputSel(limiterRefInputSel), .compCapacitanceCfg(compCapacitanceCfg),
    .limiterStatus(limiterStatus), .batteryFault(batteryFault), .groundFault(groundFault), .irq(irq),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

  pcs_pump_cell_model cell_u (.clk(clk), .ch1Drive(ch1Drive), .ch2Drive(ch2Drive), .limiterOn(limiterOn),
    .batteryShort(batteryShort), .groundShort(groundShort), .overdrive(overdrive),
    .outBatteryCmp(outBatteryCmp), .senseBatteryCmp(senseBatteryCmp), .senseGroundCmp(senseGroundCmp),
    .limiterIntervene(limiterIntervene));

  // ==========================================================
  // Helpers
  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic outs(input logic [5:0] e);
    chk(32'({ch1Drive, ch2Drive, tag1Close, tag2Close, parkingOn, pulldownOn}), 32'(e));
  endtask
  // ==========================================================
  // AXI4-Lite master
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    logic done;
    done = 1'b0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
      if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bready <= 1'b0;
        done = 1'b1;
        chk(32'(s_axi_bresp), 32'(er));
      end
    end
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [31:0] exp);
    logic done;
    done = 1'b0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rready <= 1'b0;
        done = 1'b1;
        chk(s_axi_rdata, exp);
        chk(32'(s_axi_rresp), 32'(OK));
      end
    end
  endtask

  // ==========================================================
  // Clock and watchdog
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    cyc(20000);
    errors++;
    stop_test();
  end

  // ==========================================================
  // Tests
  initial begin
    {nrst, porFault, groundShort, overdrive, batteryShort} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    errors = 0;
    samples_checked = 0;
    cyc(3);
    nrst <= 1'b1;
    cyc(6);
    outs(6'b000011);
    rdchk(CFG, 32'(pcs_pkg::CFG_RESET));
    rdchk(STA, (32'h1 << pcs_pkg::ST_PULLDOWN_BIT) | (32'h1 << pcs_pkg::ST_PARKING_BIT));
    rdchk(MSK, 32'h0);
    // Gain codes, capacitors, limiter selects
    for (int g = 0; g < 8; g++) begin
      wr(CFG, PD | 32'(g) | (32'(g * 9) << pcs_pkg::CAP_LSB) | (32'(g & 3) << pcs_pkg::LIM_SYM_BIT), OK);
      cyc(2);
      chk(32'(outputGainSel), 32'(g));
      chk(32'(compCapacitanceCfg), 32'(g * 9));
      chk(32'({limiterRefInputSel, limiterSymmetrySel}), 32'(g & 3));
    end
    // Channel and tag switch, enable drops pull-down and parking
    for (int c = 0; c < 4; c++) begin
      wr(CFG, EN | PD | (c[0] ? CH : 32'h0) | (c[1] ? TG : 32'h0), OK);
      cyc(2);
      outs({!c[0], c[0], c[1] & !c[0], c[1] & c[0], 2'b00});
    end
    wr(CFG, PD, OK);
    cyc(2);
    outs(6'b000011);
    wr(CFG, 32'h0, OK);
    cyc(2);
    outs(6'b000010);
    // Limiter
    overdrive <= 1'b1;
    wr(CFG, EN, OK);
    cyc(4);
    chk(32'({limiterOn, limiterStatus}), 32'h0);
    wr(CFG, EN | LE, OK);
    cyc(4);
    chk(32'({limiterOn, limiterStatus}), 32'h3);
    rdchk(STA, 32'h3);
    wr(CFG, LE | PD, OK);
    cyc(4);
    chk(32'({limiterOn, limiterStatus}), 32'h0);
    overdrive <= 1'b0;
    rdchk(IST, 32'h1 << pcs_pkg::IRQ_LIMITER_BIT);
    // Short to battery on sense and output pins, refused enable, interrupt
    for (int b = 2; b > 0; b--) begin
      batteryShort <= 2'(b);
      cyc(4);
      chk(32'({batteryFault, pulldownOn, irq}), 32'h4);
    end
    wr(CFG, EN | PD, OK);
    cyc(2);
    outs(6'b000010);
    wr(MSK, 32'h9, OK);
    cyc(3);
    chk(32'(irq), 32'h1);
    batteryShort <= 2'b00;
    cyc(3);
    rdchk(IST, 32'h9);
    cyc(3);
    chk(32'(irq), 32'h0);
    outs(6'b000011);
    // Short to ground
    groundShort <= 1'b1;
    cyc(4);
    chk(32'({groundFault, pulldownOn}), 32'h2);
    groundShort <= 1'b0;
    cyc(4);
    outs(6'b000011);
    // Unmapped write has no effect
    wr(STA, 32'hffff, pcs_pkg::RESP_SLVERR);
    rdchk(CFG, PD);
    // Supply fault restores defaults
    wr(CFG, EN | TG | 32'h7, OK);
    wr(MSK, 32'hf, OK);
    porFault <= 1'b1;
    cyc(pcs_pkg::POR_FILTER_CYCLES + 20);
    porFault <= 1'b0;
    cyc(4);
    outs(6'b000011);
    rdchk(CFG, 32'(pcs_pkg::CFG_RESET));
    rdchk(MSK, 32'h0);
    stop_test();
  end
endmodule // pcs_pump_source_ctrl_tb
